/* dv/bdc_host_model.sv */
// Host configuration master model driving byte accesses
`timescale 1ns/100ps
`default_nettype none
module bdc_host_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Configuration access
  output logic            cfg_rd_o,
  output logic            cfg_wr_o,
  output logic            cfg_func_o,
  output logic      [7:0] cfg_addr_o,
  output logic      [7:0] cfg_wdata_o,
  input  wire logic [7:0] cfg_rdata_i,
  input  wire logic       cfg_rvalid_i
);
  initial begin
    cfg_rd_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_func_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end
  // Released lines flip so a stale value never looks valid
  task automatic release_bus();
    cfg_func_o = ~cfg_func_o;
    cfg_addr_o = ~cfg_addr_o;
    cfg_wdata_o = ~cfg_wdata_o;
  endtask : release_bus
  task automatic cfg_write(input logic f, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    cfg_func_o = f;
    cfg_addr_o = a;
    cfg_wdata_o = (a == 8'h92) ? (d & 8'hf6) : d;
    cfg_wr_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    cfg_wr_o = 1'b0;
    release_bus();
  endtask : cfg_write
  task automatic cfg_read(input logic f, input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    @(posedge sys_clk_i);
    #1;
    cfg_func_o = f;
    cfg_addr_o = a;
    cfg_rd_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    cfg_rd_o = 1'b0;
    release_bus();
    ok = cfg_rvalid_i;
    d = cfg_rdata_i;
  endtask : cfg_read
endmodule : bdc_host_model
`default_nettype wire

/* dv/bdc_regs_top_properties.sv */
// Concurrent checks on the bridge control register ports
`timescale 1ns/100ps
`default_nettype none
module bdc_regs_top_properties
  import bdc_pkg::*;
(
  // Clock and reset
  input wire logic          sys_clk_i,
  input wire logic          sys_rst_i,
  // Configuration access
  input wire logic          cfg_rd_i,
  input wire logic          cfg_wr_i,
  input wire logic          cfg_func_i,
  input wire logic [7:0]    cfg_addr_i,
  input wire logic [7:0]    cfg_wdata_i,
  input wire logic [7:0]    cfg_rdata_o,
  input wire logic          cfg_rvalid_o,
  // Socket power inputs and derived outputs
  input wire logic [1:0]    pwr_off_req_i,
  input wire logic [1:0]    func_in_d3_i,
  input wire logic [1:0]    pwr_off_grant_o,
  input wire logic          low_voltage_capable_o,
  input wire logic [1:0]    irq_signal_mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_dc_wr; cfg_wr_i && !cfg_rd_i && cfg_addr_i == 8'h92; endsequence
  sequence s_dc_rd1; cfg_rd_i && cfg_func_i && cfg_addr_i == 8'h92; endsequence
  property p_rd_ans; cfg_rd_i |=> cfg_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rv_src; cfg_rvalid_o |-> $past(cfg_rd_i); endproperty
  a_rv_src: assert property (p_rv_src) else $error("answer without read");
  property p_cap; cfg_rd_i && cfg_addr_i == 8'ha0 |=> cfg_rdata_o == 8'h01; endproperty
  a_cap: assert property (p_cap) else $error("capability_identifier wrong");
  property p_nxt; cfg_rd_i && cfg_addr_i == 8'ha1 |=> cfg_rdata_o == 8'h00; endproperty
  a_nxt: assert property (p_nxt) else $error("next pointer not zero");
  property p_dc_rsvd; cfg_rd_i && cfg_addr_i == 8'h92 |=> !cfg_rdata_o[4]; endproperty
  a_dc_rsvd: assert property (p_dc_rsvd) else $error("devctl bit 4 set");
  property p_dg_one; cfg_rd_i && cfg_addr_i == 8'h93 |=> cfg_rdata_o[6]; endproperty
  a_dg_one: assert property (p_dg_one) else $error("diag bit 6 clear");
  property p_glob_f1; s_dc_rd1 |=> (cfg_rdata_o & 8'h49) == 8'h00; endproperty
  a_glob_f1: assert property (p_glob_f1) else $error("global bit seen by f1");
  property p_shared;
    s_dc_wr ##1 !cfg_wr_i ##1 s_dc_rd1 |=> cfg_rdata_o == ($past(cfg_wdata_i, 3) & 8'ha6);
  endproperty
  a_shared: assert property (p_shared) else $error("shared bits differ");
  // Three edges cover either output register placement
  property p_mode; s_dc_wr |-> ##3 irq_signal_mode_o == $past(cfg_wdata_i[2:1], 3); endproperty
  a_mode: assert property (p_mode) else $error("irq mode not applied");
  property p_lv;
    s_dc_wr and !cfg_func_i |-> ##3 low_voltage_capable_o == $past(cfg_wdata_i[6], 3);
  endproperty
  a_lv: assert property (p_lv) else $error("3-V force not applied");
  property p_grant; (pwr_off_grant_o & ~$past(pwr_off_req_i)) == 2'b00; endproperty
  a_grant: assert property (p_grant) else $error("grant without request");
  // Outside D3 the hold bit has no say; skip the edge right after reset
  property p_grant_free;
    !$past(sys_rst_i) && $past(func_in_d3_i) == 2'b00
      |-> pwr_off_grant_o == $past(pwr_off_req_i);
  endproperty
  a_grant_free: assert property (p_grant_free) else $error("grant withheld outside D3");
endmodule : bdc_regs_top_properties
`default_nettype wire

/* dv/bdc_regs_top_tb.sv */
// Self-checking bench for the bridge control register block
`timescale 1ns/100ps
`default_nettype none
module bdc_regs_top_tb;
  import bdc_pkg::*;
  logic          sys_clk_i, sys_rst_i, cfg_rd_i, cfg_wr_i, cfg_func_i, cfg_rvalid_o, ok;
  logic [7:0]    cfg_addr_i, cfg_wdata_i, cfg_rdata_o, legacy_805_route_i, rd;
  logic [1:0]    pwr_off_req_i, func_in_d3_i, pwr_off_grant_o, csc_event_i;
  logic [1:0]    legacy_803_bit4_i, csc_pci_irq_o, std_video_model_en_o;
  logic          low_voltage_capable_o, diag_io_bit_o, delayed_txn_disable_o;
  logic          cb_dly_start_i, cb_dly_done_i, cb_discard_o;
  logic          pci_dly_start_i, pci_dly_done_i, pci_discard_o;
  logic [6:0]    retry_latency_limit_o;
  bdc_irq_mode_t irq_signal_mode_o;
  int            errors, tests_run, n;

  initial sys_clk_i = 1'b0;
  always #5 sys_clk_i = ~sys_clk_i;

  // Short discard lengths keep the run brief
  bdc_regs_top #(.VENDOR_ID(16'h1a2b), .DEVICE_ID(16'h3c4d),
                 .DISC_SHORT_CYC(4), .DISC_LONG_CYC(16)) dut (
    .sys_clk_i, .sys_rst_i, .cfg_rd_i, .cfg_wr_i, .cfg_func_i, .cfg_addr_i, .cfg_wdata_i,
    .cfg_rdata_o, .cfg_rvalid_o, .pwr_off_req_i, .func_in_d3_i, .pwr_off_grant_o,
    .low_voltage_capable_o, .diag_io_bit_o, .irq_signal_mode_o, .csc_event_i,
    .legacy_803_bit4_i, .legacy_805_route_i, .csc_pci_irq_o, .delayed_txn_disable_o,
    .retry_latency_limit_o, .cb_dly_start_i, .cb_dly_done_i, .cb_discard_o,
    .pci_dly_start_i, .pci_dly_done_i, .pci_discard_o, .std_video_model_en_o);

  bdc_host_model host (
    .sys_clk_i(sys_clk_i), .cfg_rd_o(cfg_rd_i), .cfg_wr_o(cfg_wr_i), .cfg_func_o(cfg_func_i),
    .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i), .cfg_rdata_i(cfg_rdata_o),
    .cfg_rvalid_i(cfg_rvalid_o));

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic rdchk(input logic f, input logic [7:0] a, input logic [7:0] exp);
    host.cfg_read(f, a, rd, ok);
    check("rvalid", 8'h01, {7'h0, ok});
    check($sformatf("rdata %h f%0d", a, f), exp, rd);
  endtask : rdchk

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : settle

  // Cycles from start to discard pulse; 41 means none
  task automatic disc(input logic cb, input int abort, input int exp);
    @(posedge sys_clk_i);
    #1;
    cb_dly_start_i = cb;
    pci_dly_start_i = !cb;
    @(posedge sys_clk_i);
    #1;
    cb_dly_start_i = 1'b0;
    pci_dly_start_i = 1'b0;
    for (n = 1; n <= 40; n++) begin
      @(posedge sys_clk_i);
      #1;
      cb_dly_done_i = (n == abort);
      pci_dly_done_i = (n == abort);
      if ((cb ? cb_discard_o : pci_discard_o) === 1'b1) break;
    end
    check("discard cycles", exp[7:0], n[7:0]);
  endtask : disc

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    summarize();
  end

  initial begin
    sys_rst_i = 1'b1;
    {pwr_off_req_i, func_in_d3_i, csc_event_i, legacy_803_bit4_i} = 8'h00;
    {cb_dly_start_i, cb_dly_done_i, pci_dly_start_i, pci_dly_done_i} = 4'h0;
    legacy_805_route_i = 8'h50;
    repeat (10) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    rdchk(0, 8'h92, 8'h66);
    rdchk(1, 8'h92, 8'h26);
    rdchk(0, 8'h93, 8'h60);
    rdchk(1, 8'h93, 8'h60);
    rdchk(1, 8'ha1, 8'h00);
    rdchk(0, 8'he0, 8'h00);
    rdchk(0, 8'h00, 8'h2b);
    check("opts", 8'h6f, {1'b0, low_voltage_capable_o, diag_io_bit_o, delayed_txn_disable_o,
          irq_signal_mode_o, std_video_model_en_o});
    check("retry", 8'd16, {1'b0, retry_latency_limit_o});
    host.cfg_write(0, 8'ha0, 8'hff);
    rdchk(0, 8'ha0, 8'h01);
    host.cfg_write(0, 8'h92, 8'hff);
    rdchk(1, 8'h92, 8'ha6);
    rdchk(0, 8'h92, 8'he6);
    host.cfg_write(1, 8'h92, 8'h00);
    rdchk(0, 8'h92, 8'h40);
    settle();
    check("opts", 8'h43, {1'b0, low_voltage_capable_o, diag_io_bit_o, delayed_txn_disable_o,
          irq_signal_mode_o, std_video_model_en_o});
    for (int m = 0; m < 4; m++) begin
      host.cfg_write(0, 8'h92, {5'h0, m[1:0], 1'b0});
      settle();
      check("irq mode", {6'h0, m[1:0]}, {6'h0, irq_signal_mode_o});
    end
    check("lv", 8'h00, {7'h0, low_voltage_capable_o});
    pwr_off_req_i = 2'b11;
    func_in_d3_i = 2'b01;
    settle();
    check("grant", 8'h03, {6'h0, pwr_off_grant_o});
    host.cfg_write(1, 8'h92, 8'h80);
    settle();
    check("grant hold", 8'h02, {6'h0, pwr_off_grant_o});
    func_in_d3_i = 2'b00;
    settle();
    check("grant no d3", 8'h03, {6'h0, pwr_off_grant_o});
    host.cfg_write(0, 8'h93, 8'hff);
    host.cfg_write(1, 8'h93, 8'h00);
    settle();
    rdchk(0, 8'h93, 8'hff);
    rdchk(1, 8'h93, 8'h40);
    rdchk(1, 8'h02, 8'hff);
    check("dly dis", 8'h01, {7'h0, delayed_txn_disable_o});
    check("retry", 8'd64, {1'b0, retry_latency_limit_o});
    check("video", 8'h02, {6'h0, std_video_model_en_o});
    csc_event_i = 2'b11;
    settle();
    check("csc", 8'h01, {6'h0, csc_pci_irq_o});
    legacy_803_bit4_i = 2'b11;
    settle();
    check("csc", 8'h03, {6'h0, csc_pci_irq_o});
    legacy_805_route_i = 8'h05;
    settle();
    check("csc", 8'h02, {6'h0, csc_pci_irq_o});
    disc(1, 0, 41);
    host.cfg_write(0, 8'h93, 8'h04);
    settle();
    rdchk(0, 8'h01, 8'h1a);
    disc(1, 0, 4);
    disc(0, 0, 16);
    disc(0, 3, 41);
    host.cfg_write(0, 8'h93, 8'h02);
    settle();
    disc(1, 0, 16);
    disc(0, 0, 4);
    check("retry", 8'd16, {1'b0, retry_latency_limit_o});
    sys_rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    rdchk(0, 8'h92, 8'h66);
    rdchk(0, 8'h93, 8'h60);
    rdchk(1, 8'h93, 8'h60);
    summarize();
  end
endmodule : bdc_regs_top_tb

bind bdc_regs_top bdc_regs_top_properties u_props (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
  .cfg_func_i(cfg_func_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .pwr_off_req_i(pwr_off_req_i),
  .func_in_d3_i(func_in_d3_i),
  .pwr_off_grant_o(pwr_off_grant_o), .low_voltage_capable_o(low_voltage_capable_o),
  .irq_signal_mode_o(irq_signal_mode_o));
`default_nettype wire

/* hw/bdc_byte_reg.sv */
// Byte-wide control register with per-bit write enable
`timescale 1ns/100ps
`default_nettype none

module bdc_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wmask_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_o <= RST_VAL;
    end else if (wr_i) begin
      q_o <= (q_o & ~wmask_i) | (wdata_i & wmask_i);
    end
  end

endmodule : bdc_byte_reg

`default_nettype wire

/* hw/bdc_consts.svh */
// Offsets, field positions, reset values and timing counts of the control bytes
`ifndef BDC_CONSTS_SVH
`define BDC_CONSTS_SVH

`define BDC_OFS_VENDOR_LO    8'h00
`define BDC_OFS_VENDOR_HI    8'h01
`define BDC_OFS_DEVICE_LO    8'h02
`define BDC_OFS_DEVICE_HI    8'h03
`define BDC_OFS_DEVCTL       8'h92
`define BDC_OFS_DIAG         8'h93
`define BDC_OFS_CAP_ID       8'ha0
`define BDC_OFS_NEXT_PTR     8'ha1

`define BDC_DEVCTL_RST       8'h66
`define BDC_DIAG_RST         8'h60
`define BDC_CAP_ID_VAL       8'h01
`define BDC_NEXT_PTR_VAL     8'h00

// Device control bit positions
`define BDC_DC_PWR_HOLD      7
`define BDC_DC_LV_FORCE      6
`define BDC_DC_DIAG_IO       5
`define BDC_DC_MODE_HI       2
`define BDC_DC_MODE_LO       1
// Device control masks: shared bits, global bits
`define BDC_DC_SHARED_MASK   8'ha6
`define BDC_DC_GLOBAL_MASK   8'h49

// Diagnostic bit positions
`define BDC_DG_ID_MASK       7
`define BDC_DG_RSVD_ONE      6
`define BDC_DG_CSC_ROUTE     5
`define BDC_DG_DLY_DIS       4
`define BDC_DG_RETRY_LATENCY_EXTEND     3
`define BDC_DG_CB_DISC       2
`define BDC_DG_PCI_DISC      1
`define BDC_DG_ZV_DIS        0
// Diagnostic masks: per-function, global, read-as-one
`define BDC_DG_LOCAL_MASK    8'h21
`define BDC_DG_GLOBAL_MASK   8'h9e
`define BDC_DG_ONE_MASK      8'h40

`define BDC_RETRY_LAT_BASE   7'd16
`define BDC_RETRY_LAT_EXT    7'd64

// Discard timer lengths in bus clocks
`define BDC_DISC_SHORT_EXP   10
`define BDC_DISC_LONG_EXP    15
`define BDC_DISC_SHORT_CYC   (1 << `BDC_DISC_SHORT_EXP)
`define BDC_DISC_LONG_CYC    (1 << `BDC_DISC_LONG_EXP)
`define BDC_DISC_CNT_W       16

`endif

/* hw/bdc_discard_tmr.sv */
// Delayed-transaction discard timer with selectable length
`timescale 1ns/100ps
`default_nettype none
`include "bdc_consts.svh"

module bdc_discard_tmr
  import bdc_pkg::*;
#(
  parameter int SHORT_CYC = `BDC_DISC_SHORT_CYC,
  parameter int LONG_CYC  = `BDC_DISC_LONG_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic start_i,
  input  wire logic done_i,
  input  wire logic sel_short_i,
  output logic      expired_o
);

  localparam logic [`BDC_DISC_CNT_W-1:0] SHORT_LAST = `BDC_DISC_CNT_W'(SHORT_CYC - 1);
  localparam logic [`BDC_DISC_CNT_W-1:0] LONG_LAST  = `BDC_DISC_CNT_W'(LONG_CYC - 1);

  bdc_tmr_state_t              state_reg;
  logic [`BDC_DISC_CNT_W-1:0]  cnt_reg;
  logic [`BDC_DISC_CNT_W-1:0]  last_reg;

  // Length is latched at start so a mid-flight write cannot shorten it
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= BDC_TMR_IDLE;
      cnt_reg   <= '0;
      last_reg  <= LONG_LAST;
      expired_o <= 1'b0;
    end else begin
      expired_o <= 1'b0;
      case (state_reg)
        BDC_TMR_IDLE: begin
          cnt_reg <= '0;
          if (start_i && !done_i) begin
            state_reg <= BDC_TMR_RUN;
            last_reg  <= sel_short_i ? SHORT_LAST : LONG_LAST;
          end
        end
        BDC_TMR_RUN: begin
          if (done_i) begin
            state_reg <= BDC_TMR_IDLE;
          end else if (cnt_reg == last_reg) begin
            state_reg <= BDC_TMR_IDLE;
            expired_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= BDC_TMR_IDLE;
        end
      endcase
    end
  end

endmodule : bdc_discard_tmr

`default_nettype wire

/* hw/bdc_pkg.sv */
// Types shared by the bridge control register block
package bdc_pkg;

  typedef enum logic [1:0] {
    BDC_IRQ_PAR_PCI     = 2'b00,
    BDC_IRQ_PAR_BOTH    = 2'b01,
    BDC_IRQ_SER_IRQ     = 2'b10,
    BDC_IRQ_SER_BOTH    = 2'b11
  } bdc_irq_mode_t;

  typedef enum logic {
    BDC_TMR_IDLE = 1'b0,
    BDC_TMR_RUN  = 1'b1
  } bdc_tmr_state_t;

endpackage : bdc_pkg

/* hw/bdc_regs_top.sv */
// Bridge device control, diagnostic and capability header bytes
`timescale 1ns/100ps
`default_nettype none
`include "bdc_consts.svh"

module bdc_regs_top
  import bdc_pkg::*;
#(
  // Arbitrary identification values
  parameter logic [15:0] VENDOR_ID        = 16'h1a2b,
  parameter logic [15:0] DEVICE_ID        = 16'h3c4d,
  parameter int          DISC_SHORT_CYC   = `BDC_DISC_SHORT_CYC,
  parameter int          DISC_LONG_CYC    = `BDC_DISC_LONG_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // Configuration access
  input  wire logic       cfg_rd_i,
  input  wire logic       cfg_wr_i,
  input  wire logic       cfg_func_i,
  input  wire logic [7:0] cfg_addr_i,
  input  wire logic [7:0] cfg_wdata_i,
  output logic      [7:0] cfg_rdata_o,
  output logic            cfg_rvalid_o,
  // Socket power
  input  wire logic [1:0] pwr_off_req_i,
  input  wire logic [1:0] func_in_d3_i,
  output logic      [1:0] pwr_off_grant_o,
  // Socket and interrupt configuration
  output logic            low_voltage_capable_o,
  output logic            diag_io_bit_o,
  output bdc_irq_mode_t   irq_signal_mode_o,
  // Card status change routing
  input  wire logic [1:0] csc_event_i,
  input  wire logic [1:0] legacy_803_bit4_i,
  input  wire logic [7:0] legacy_805_route_i,
  output logic      [1:0] csc_pci_irq_o,
  // Delayed transaction control
  output logic            delayed_txn_disable_o,
  output logic      [6:0] retry_latency_limit_o,
  input  wire logic       cb_dly_start_i,
  input  wire logic       cb_dly_done_i,
  output logic            cb_discard_o,
  input  wire logic       pci_dly_start_i,
  input  wire logic       pci_dly_done_i,
  output logic            pci_discard_o,
  // Zoomed video model
  output logic      [1:0] std_video_model_en_o
);

  logic [7:0] devctl_q;
  logic [7:0] diag0_q;
  logic [7:0] diag1_q;
  logic       wr_devctl;
  logic       wr_diag0;
  logic       wr_diag1;
  logic [7:0] devctl_wmask;
  logic [7:0] rdata_next;
  logic       id_mask;

  assign wr_devctl = cfg_wr_i && (cfg_addr_i == `BDC_OFS_DEVCTL);
  assign wr_diag0  = cfg_wr_i && !cfg_func_i && (cfg_addr_i == `BDC_OFS_DIAG);
  assign wr_diag1  = cfg_wr_i && cfg_func_i && (cfg_addr_i == `BDC_OFS_DIAG);

  assign devctl_wmask = cfg_func_i ? `BDC_DC_SHARED_MASK
                                   : (`BDC_DC_SHARED_MASK | `BDC_DC_GLOBAL_MASK);

  bdc_byte_reg #(
    .RST_VAL (`BDC_DEVCTL_RST)
  ) u_devctl (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_devctl),
    .wmask_i   (devctl_wmask),
    .wdata_i   (cfg_wdata_i),
    .q_o       (devctl_q)
  );

  bdc_byte_reg #(
    .RST_VAL (`BDC_DIAG_RST)
  ) u_diag0 (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_diag0),
    .wmask_i   (`BDC_DG_LOCAL_MASK | `BDC_DG_GLOBAL_MASK),
    .wdata_i   (cfg_wdata_i),
    .q_o       (diag0_q)
  );

  // function 1 holds only its local bits
  bdc_byte_reg #(
    .RST_VAL (`BDC_DIAG_RST)
  ) u_diag1 (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_i      (wr_diag1),
    .wmask_i   (`BDC_DG_LOCAL_MASK),
    .wdata_i   (cfg_wdata_i),
    .q_o       (diag1_q)
  );

  assign id_mask = diag0_q[`BDC_DG_ID_MASK];

  // Read data multiplexer
  always_comb begin
    rdata_next = 8'h00;
    case (cfg_addr_i)
      `BDC_OFS_VENDOR_LO: begin
        rdata_next = id_mask ? 8'hff : VENDOR_ID[7:0];
      end
      `BDC_OFS_VENDOR_HI: begin
        rdata_next = id_mask ? 8'hff : VENDOR_ID[15:8];
      end
      `BDC_OFS_DEVICE_LO: begin
        rdata_next = id_mask ? 8'hff : DEVICE_ID[7:0];
      end
      `BDC_OFS_DEVICE_HI: begin
        rdata_next = id_mask ? 8'hff : DEVICE_ID[15:8];
      end
      // global bits hidden from function 1
      `BDC_OFS_DEVCTL: begin
        rdata_next = cfg_func_i ? (devctl_q & `BDC_DC_SHARED_MASK)
                                : (devctl_q & (`BDC_DC_SHARED_MASK | `BDC_DC_GLOBAL_MASK));
      end
      `BDC_OFS_DIAG: begin
        rdata_next = cfg_func_i ? ((diag1_q & `BDC_DG_LOCAL_MASK) | `BDC_DG_ONE_MASK)
                                : (diag0_q | `BDC_DG_ONE_MASK);
      end
      `BDC_OFS_CAP_ID: begin
        rdata_next = `BDC_CAP_ID_VAL;
      end
      `BDC_OFS_NEXT_PTR: begin
        rdata_next = `BDC_NEXT_PTR_VAL;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read answer one clock after the strobe
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o  <= 8'h00;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= rdata_next;
      end
    end
  end

  // Socket power gate
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pwr_off_grant_o <= 2'b00;
    end else begin
      pwr_off_grant_o <= pwr_off_req_i
                       & ~({2{devctl_q[`BDC_DC_PWR_HOLD]}} & func_in_d3_i);
    end
  end

  // Socket and interrupt mode outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_voltage_capable_o <= 1'(`BDC_DEVCTL_RST >> `BDC_DC_LV_FORCE);
      diag_io_bit_o         <= 1'(`BDC_DEVCTL_RST >> `BDC_DC_DIAG_IO);
      irq_signal_mode_o     <= BDC_IRQ_SER_BOTH;
    end else begin
      low_voltage_capable_o <= devctl_q[`BDC_DC_LV_FORCE];
      diag_io_bit_o         <= devctl_q[`BDC_DC_DIAG_IO];
      irq_signal_mode_o     <= bdc_irq_mode_t'(devctl_q[`BDC_DC_MODE_HI:`BDC_DC_MODE_LO]);
    end
  end

  // Card status change routing per function
  logic [1:0] csc_route_sel;
  logic [1:0] csc_route_ok;

  assign csc_route_sel = {diag1_q[`BDC_DG_CSC_ROUTE], diag0_q[`BDC_DG_CSC_ROUTE]};

  always_comb begin
    csc_route_ok = 2'b00;
    for (int f = 0; f < 2; f++) begin
      csc_route_ok[f] = csc_route_sel[f] ? (legacy_805_route_i[f*4 +: 4] == 4'h0)
                                         : legacy_803_bit4_i[f];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      csc_pci_irq_o <= 2'b00;
    end else begin
      csc_pci_irq_o <= csc_event_i & csc_route_ok;
    end
  end

  // Delayed transaction options
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      delayed_txn_disable_o <= 1'b0;
      retry_latency_limit_o <= `BDC_RETRY_LAT_BASE;
    end else begin
      delayed_txn_disable_o <= diag0_q[`BDC_DG_DLY_DIS];
      retry_latency_limit_o <= diag0_q[`BDC_DG_RETRY_LATENCY_EXTEND] ? `BDC_RETRY_LAT_EXT
                                                          : `BDC_RETRY_LAT_BASE;
    end
  end

  // Timers cannot start while delayed transactions are disabled; a timer already running keeps counting
  // card-side discard length
  bdc_discard_tmr #(
    .SHORT_CYC (DISC_SHORT_CYC),
    .LONG_CYC  (DISC_LONG_CYC)
  ) u_cb_disc (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .start_i     (cb_dly_start_i && !diag0_q[`BDC_DG_DLY_DIS]),
    .done_i      (cb_dly_done_i),
    .sel_short_i (diag0_q[`BDC_DG_CB_DISC]),
    .expired_o   (cb_discard_o)
  );

  bdc_discard_tmr #(
    .SHORT_CYC (DISC_SHORT_CYC),
    .LONG_CYC  (DISC_LONG_CYC)
  ) u_pci_disc (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .start_i     (pci_dly_start_i && !diag0_q[`BDC_DG_DLY_DIS]),
    .done_i      (pci_dly_done_i),
    .sel_short_i (diag0_q[`BDC_DG_PCI_DISC]),
    .expired_o   (pci_discard_o)
  );

  // Zoomed video model enable per function
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      std_video_model_en_o <= 2'b11;
    end else begin
      std_video_model_en_o <= ~{diag1_q[`BDC_DG_ZV_DIS], diag0_q[`BDC_DG_ZV_DIS]};
    end
  end

endmodule : bdc_regs_top

`default_nettype wire
